// ### design/dcd_pkg.sv
// package: register map, field layout and bus carriers of the dual channel dma
package dcd_pkg;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [15:0] ADDR_VID_START = 16'h8580;
    localparam logic [15:0] ADDR_VID_LEN   = 16'h8584;
    localparam logic [15:0] ADDR_VID_GO    = 16'h8588;
    localparam logic [15:0] ADDR_CMD_BASE  = 16'h8590;
    localparam logic [15:0] ADDR_CMD_WPTR  = 16'h8594;
    localparam logic [15:0] ADDR_CMD_RPTR  = 16'h8598;
    localparam logic [15:0] ADDR_CMD_GO    = 16'h859c;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int DIR_BIT    = 1;
    localparam int RUN_BIT    = 0;
    localparam int BSIZE_BIT  = 1;
    localparam int WPU_BIT    = 16;
    localparam int LEN_MSB    = 23;
    localparam int PTR_MSB    = 15;
    localparam int PTR_LSB    = 2;
    localparam int BASE_LSB   = 12;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [13:0] RST_PTR  = 14'h0000;
    localparam logic [21:0] RST_CNT  = 22'h00_0000;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [15:0] adr;
        logic [31:0] dat;
    } dcd_wb_req_s;

    // one master read or write request towards system memory
    typedef struct packed {
        logic        valid;
        logic        we;
        logic [31:0] adr;
        logic [31:0] dat;
    } dcd_mem_req_s;

endpackage

// ### design/dcd_wb_slave.sv
// classic wishbone slave front end with one-cycle registered ack
`timescale 1ns/1ns
module dcd_wb_slave import dcd_pkg::*; (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone request
    input  wire dcd_wb_req_s wb_i,
    // decoded access, one-cycle pulses
    output logic             wr_o,
    output logic             rd_o,
    output logic             ack_o
);
    logic ack_q;
    logic ack_d;

    always_comb begin
        ack_d = wb_i.cyc && wb_i.stb && !ack_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // a write takes effect on the edge where ack is seen high; read data is captured one edge earlier
    assign wr_o  = ack_q && wb_i.cyc && wb_i.stb && wb_i.we;
    assign rd_o  = ack_d && !wb_i.we;
    assign ack_o = ack_q;
endmodule // dcd_wb_slave

// ### design/dcd_dma_top.sv
// top: video/graphics dma channel and command dma channel behind wishbone
//
// Contract
// (R1) direction bit 1 of start register: 0 memory to output fifo, 1 video to memory.
// (R2) video system address comes from start register bits 31-2, doubleword aligned.
// (R3) output fifo data routes to decoder or video memory, optional decimation.
// (R4) video channel moves length bits 23-2 plus one doublewords.
// (R5) writing video enable bit 0 starts, writing zero stops the transfer.
// (R6) device clears video enable when the transfer completes.
// (R7) buffer size bit: 0 selects 4 KB, 1 selects 64 KB ring.
// (R8) command buffer base is held in base register bits 31-12.
// (R9) software keeps base bits 15-12 zero for the 64 KB ring.
// (R10) write pointer bits 15-2 give the fill limit offset.
// (R11) software sets bit 16 on each write pointer update.
// (R12) read pointer bits 15-2 hold the next doubleword to fetch.
// (R13) 4 KB fetch address is base 31-12, pointer 11-2, two zeros.
// (R14) 64 KB fetch address is base 31-16, pointer 15-2, two zeros.
// (R15) device advances read pointer after software initialises it.
// (R16) command enable bit 0 allows fetching when set.
// (R17) software writes zeros to reserved bits; reads of them are zero.
// (R18) fetched command data goes to the rendering engine.
// (R19) both channels run independently of each other.
// (R20) fetch only while pointers differ; wrap pointer at ring end.
// (R21) stall output fifo writes while full, losing and repeating nothing.
`timescale 1ns/1ns
module dcd_dma_top import dcd_pkg::*; (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // wishbone slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [15:0]  wb_adr_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    // video channel system memory master
    output dcd_mem_req_s      vmem_req_o,
    input  wire logic         vmem_ack_i,
    input  wire logic [31:0]  vmem_dat_i,
    // video memory read source (video to system direction)
    output logic              vram_rd_o,
    input  wire logic         vram_valid_i,
    input  wire logic [31:0]  vram_dat_i,
    // local peripheral bus output fifo
    output logic              lpb_valid_o,
    output logic      [31:0]  lpb_dat_o,
    input  wire logic         lpb_full_i,
    // command channel system memory master
    output dcd_mem_req_s      cmem_req_o,
    input  wire logic         cmem_ack_i,
    input  wire logic [31:0]  cmem_dat_i,
    // rendering engine command stream
    output logic              eng_valid_o,
    output logic      [31:0]  eng_dat_o,
    input  wire logic         eng_ready_i
);
    // ************************************************************
    // bus slave
    // ************************************************************
    dcd_wb_req_s wb_req;
    logic        reg_wr;
    logic        reg_rd;
    logic        ack_w;
    assign wb_req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                      adr: wb_adr_i, dat: wb_dat_i};
    dcd_wb_slave u_slave (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .wb_i  (wb_req),
        .wr_o  (reg_wr),
        .rd_o  (reg_rd),
        .ack_o (ack_w)
    );
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction
    function automatic logic hit(input logic [15:0] a);
        return reg_wr && (wb_adr_i == a);
    endfunction
    // ************************************************************
    // registers and channel state
    // ************************************************************
    typedef enum { V_IDLE, V_SYS_RD, V_FIFO_WR, V_VRAM_RD, V_SYS_WR } dcd_vst_e;
    typedef enum { C_IDLE, C_FETCH, C_DELIVER } dcd_cst_e;
    logic [31:0] vstart_q, vstart_d;
    logic [31:0] vlen_q, vlen_d;
    logic        vrun_q, vrun_d;
    logic [31:0] cbase_q, cbase_d;
    logic [13:0] wptr_q, wptr_d;
    logic        wpu_q, wpu_d;
    logic [13:0] rptr_q, rptr_d;
    logic        crun_q, crun_d;
    dcd_vst_e    vst_q, vst_d;
    dcd_cst_e    cst_q, cst_d;
    logic [29:0] vaddr_q, vaddr_d;
    logic [21:0] vcnt_q, vcnt_d;
    logic [31:0] vdat_q, vdat_d;
    logic [31:0] cdat_q, cdat_d;
    logic [31:0] rdat_q, rdat_d;
    dcd_mem_req_s vreq_q, vreq_d;
    dcd_mem_req_s creq_q, creq_d;
    logic        vram_rd_q, vram_rd_d;
    logic        lpbv_q, lpbv_d;
    logic        engv_q, engv_d;
    // ring offset mask: 4 KB keeps pointer bits 11-2, 64 KB bits 15-2
    function automatic logic [13:0] ring_mask(input logic big);
        return big ? 14'h3fff : 14'h03ff;                                    // [R7]
    endfunction
    function automatic logic [31:0] fetch_addr(input logic [31:0] base, input logic [13:0] rp,
                                               input logic big);
        if (big) return {base[31:16], rp[13:0], 2'b00};                      // [R14]
        else     return {base[31:BASE_LSB], rp[9:0], 2'b00};                 // [R13] [R8]
    endfunction
    logic        big;
    logic [13:0] mask;
    assign big  = cbase_q[BSIZE_BIT];
    assign mask = ring_mask(big);
    // ************************************************************
    // register writes and video channel
    // ************************************************************
    always_comb begin
        vstart_d  = vstart_q;
        vlen_d    = vlen_q;
        vrun_d    = vrun_q;
        vst_d     = vst_q;
        vaddr_d   = vaddr_q;
        vcnt_d    = vcnt_q;
        vdat_d    = vdat_q;
        vreq_d    = vreq_q;
        vram_rd_d = 1'b0;
        lpbv_d    = lpbv_q;
        if (hit(ADDR_VID_START)) vstart_d = merge(vstart_q, wb_dat_i, wb_sel_i) & 32'hffff_fffe;
        if (hit(ADDR_VID_LEN))   vlen_d   = merge(vlen_q, wb_dat_i, wb_sel_i) & 32'h00ff_fffc;
        case (vst_q)
            V_IDLE: begin
                if (vrun_q) begin
                    vaddr_d = vstart_q[31:PTR_LSB];                          // [R2]
                    vcnt_d  = vlen_q[LEN_MSB:PTR_LSB];                       // [R4]
                    vst_d   = vstart_q[DIR_BIT] ? V_VRAM_RD : V_SYS_RD;      // [R1]
                end
            end
            V_SYS_RD: begin
                vreq_d = '{valid: 1'b1, we: 1'b0, adr: {vaddr_q, 2'b00}, dat: RST_WORD};
                if (vreq_q.valid && vmem_ack_i) begin
                    vreq_d = '0;
                    vdat_d = vmem_dat_i;
                    vst_d  = V_FIFO_WR;
                end
            end
            V_FIFO_WR: begin
                // fifo data then goes on to the decoder or video memory [R3]
                lpbv_d = 1'b0;
                if (!lpbv_q && !lpb_full_i) begin                            // [R21]
                    lpbv_d = 1'b1;
                end else if (lpbv_q) begin
                    vst_d = V_IDLE;
                end
            end
            V_VRAM_RD: begin
                if (vram_valid_i) begin
                    vdat_d = vram_dat_i;
                    vst_d  = V_SYS_WR;
                end
            end
            V_SYS_WR: begin
                vreq_d = '{valid: 1'b1, we: 1'b1, adr: {vaddr_q, 2'b00}, dat: vdat_q};
                if (vreq_q.valid && vmem_ack_i) begin
                    vreq_d = '0;
                    vst_d  = V_IDLE;
                end
            end
            default: vst_d = V_IDLE;
        endcase
        // one doubleword done: count down or finish
        if ((vst_q == V_FIFO_WR && lpbv_q) ||
            (vst_q == V_SYS_WR && vreq_q.valid && vmem_ack_i)) begin
            vaddr_d = vaddr_q + 30'd1;
            if (vcnt_q == RST_CNT) begin
                vrun_d = 1'b0;                                               // [R6]
                vst_d  = V_IDLE;
            end else begin
                vcnt_d = vcnt_q - 22'd1;
                vst_d  = vstart_q[DIR_BIT] ? V_VRAM_RD : V_SYS_RD;
            end
        end
        if (hit(ADDR_VID_GO) && wb_sel_i[0]) begin
            vrun_d = wb_dat_i[RUN_BIT];                                      // [R5]
            if (!wb_dat_i[RUN_BIT]) begin
                vst_d  = V_IDLE;
                vreq_d = '0;
                lpbv_d = 1'b0;
            end
        end
        // one read pulse per doubleword, on entry to the wait state
        vram_rd_d = (vst_d == V_VRAM_RD) && (vst_q != V_VRAM_RD);            // [R1]
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vstart_q  <= RST_WORD;
            vlen_q    <= RST_WORD;
            vrun_q    <= 1'b0;
            vst_q     <= V_IDLE;
            vaddr_q   <= '0;
            vcnt_q    <= RST_CNT;
            vdat_q    <= RST_WORD;
            vreq_q    <= '0;
            vram_rd_q <= 1'b0;
            lpbv_q    <= 1'b0;
        end else begin
            vstart_q  <= vstart_d;
            vlen_q    <= vlen_d;
            vrun_q    <= vrun_d;
            vst_q     <= vst_d;
            vaddr_q   <= vaddr_d;
            vcnt_q    <= vcnt_d;
            vdat_q    <= vdat_d;
            vreq_q    <= vreq_d;
            vram_rd_q <= vram_rd_d;
            lpbv_q    <= lpbv_d;
        end
    end
    // ************************************************************
    // command channel, independent of the video channel [R19]
    // ************************************************************
    always_comb begin
        cbase_d = cbase_q;
        wptr_d  = wptr_q;
        wpu_d   = wpu_q;
        rptr_d  = rptr_q;
        crun_d  = crun_q;
        cst_d   = cst_q;
        cdat_d  = cdat_q;
        creq_d  = creq_q;
        engv_d  = engv_q;
        if (hit(ADDR_CMD_BASE)) cbase_d = merge(cbase_q, wb_dat_i, wb_sel_i) & 32'hffff_f002;
        if (hit(ADDR_CMD_WPTR)) begin
            wptr_d = wb_dat_i[PTR_MSB:PTR_LSB];                              // [R10]
            wpu_d  = wb_dat_i[WPU_BIT];                                      // [R11]
        end
        if (hit(ADDR_CMD_GO) && wb_sel_i[0]) crun_d = wb_dat_i[RUN_BIT];
        case (cst_q)
            C_IDLE: begin
                if (crun_q && ((rptr_q & mask) != (wptr_q & mask))) begin    // [R16] [R20]
                    cst_d = C_FETCH;
                end
            end
            C_FETCH: begin
                creq_d = '{valid: 1'b1, we: 1'b0, adr: fetch_addr(cbase_q, rptr_q, big),
                           dat: RST_WORD};
                if (creq_q.valid && cmem_ack_i) begin
                    creq_d = '0;
                    cdat_d = cmem_dat_i;
                    engv_d = 1'b1;
                    rptr_d = (rptr_q + 14'd1) & mask;                        // [R15] [R20]
                    cst_d  = C_DELIVER;
                end
            end
            C_DELIVER: begin
                if (engv_q && eng_ready_i) begin                             // [R18]
                    engv_d = 1'b0;
                    cst_d  = C_IDLE;
                end
            end
            default: cst_d = C_IDLE;
        endcase
        // software may reload the read pointer; the device overrides only on fetch
        if (hit(ADDR_CMD_RPTR) && !(cst_q == C_FETCH && creq_q.valid && cmem_ack_i)) begin
            rptr_d = wb_dat_i[PTR_MSB:PTR_LSB];                              // [R12]
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cbase_q <= RST_WORD;
            wptr_q  <= RST_PTR;
            wpu_q   <= 1'b0;
            rptr_q  <= RST_PTR;
            crun_q  <= 1'b0;
            cst_q   <= C_IDLE;
            cdat_q  <= RST_WORD;
            creq_q  <= '0;
            engv_q  <= 1'b0;
        end else begin
            cbase_q <= cbase_d;
            wptr_q  <= wptr_d;
            wpu_q   <= wpu_d;
            rptr_q  <= rptr_d;
            crun_q  <= crun_d;
            cst_q   <= cst_d;
            cdat_q  <= cdat_d;
            creq_q  <= creq_d;
            engv_q  <= engv_d;
        end
    end
    // ************************************************************
    // read back, reserved bits read as zero [R17]
    // ************************************************************
    always_comb begin
        rdat_d = rdat_q;
        if (reg_rd) begin
            case (wb_adr_i)
                ADDR_VID_START: rdat_d = vstart_q;
                ADDR_VID_LEN:   rdat_d = vlen_q;
                ADDR_VID_GO:    rdat_d = {31'd0, vrun_q};
                ADDR_CMD_BASE:  rdat_d = cbase_q;
                ADDR_CMD_WPTR:  rdat_d = {15'd0, wpu_q, wptr_q, 2'b00};
                ADDR_CMD_RPTR:  rdat_d = {16'd0, rptr_q, 2'b00};
                ADDR_CMD_GO:    rdat_d = {31'd0, crun_q};
                default:        rdat_d = RST_WORD;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= RST_WORD;
        end else begin
            rdat_q <= rdat_d;
        end
    end
    assign wb_dat_o    = rdat_q;
    assign wb_ack_o    = ack_w;
    assign vmem_req_o  = vreq_q;
    assign vram_rd_o   = vram_rd_q;
    assign lpb_valid_o = lpbv_q;
    assign lpb_dat_o   = vdat_q;
    assign cmem_req_o  = creq_q;
    assign eng_valid_o = engv_q;
    assign eng_dat_o   = cdat_q;
endmodule // dcd_dma_top

// ### test/dcd_mem_model.sv
// partner: system memory answering one master request after a set delay
`timescale 1ns/1ns
module dcd_mem_model import dcd_pkg::*; #(
    parameter int DELAY = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // master request and answer
    input  wire dcd_mem_req_s req_i,
    output logic              ack_o,
    output logic      [31:0]  dat_o
);
    int cnt;
    logic hit;

    assign hit = !rst_i && !ack_o && req_i.valid && cnt >= DELAY;

    always @(posedge clk_i) begin
        if (rst_i || ack_o || !req_i.valid) begin
            ack_o <= 1'b0;
            cnt   <= 0;
        end else if (hit) begin
            ack_o <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
        // outside an answer the data lines keep changing
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else begin
            dat_o <= hit ? (req_i.adr ^ 32'h5a5a_0000) : ~dat_o;
        end
    end
endmodule // dcd_mem_model

// ### test/dcd_dma_checker.sv
// checker: port-level assertions for the dual channel dma top
`timescale 1ns/1ns
module dcd_dma_checker import dcd_pkg::*; (
    // clock and reset
    input wire logic         clk_i,
    input wire logic         rst_i,
    // watched ports
    input wire logic         wb_cyc_i,
    input wire logic         wb_stb_i,
    input wire logic         wb_ack_o,
    input wire logic         wb_we_i,
    input wire logic [15:0]  wb_adr_i,
    input wire dcd_mem_req_s vmem_req_o,
    input wire logic         vmem_ack_i,
    input wire dcd_mem_req_s cmem_req_o,
    input wire logic         lpb_valid_o,
    input wire logic         lpb_full_i,
    input wire logic         vram_rd_o,
    input wire logic         eng_valid_o,
    input wire logic [31:0]  eng_dat_o,
    input wire logic         eng_ready_i
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ********************
    // properties
    // ********************
    property p_ack_one;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_vmem_hold;
        vmem_req_o.valid && !vmem_ack_i && !(wb_ack_o && wb_we_i && wb_adr_i == ADDR_VID_GO)
            |=> vmem_req_o.valid && $stable(vmem_req_o);
    endproperty
    property p_vmem_drop;
        vmem_req_o.valid && vmem_ack_i |=> !vmem_req_o.valid;
    endproperty
    property p_vmem_align;
        vmem_req_o.valid |-> vmem_req_o.adr[1:0] == 2'b00;
    endproperty
    property p_cmem_read;
        cmem_req_o.valid |-> !cmem_req_o.we && cmem_req_o.adr[1:0] == 2'b00;
    endproperty
    property p_lpb_full;
        lpb_full_i |=> !lpb_valid_o;
    endproperty
    property p_lpb_pulse;
        lpb_valid_o |=> !lpb_valid_o;
    endproperty
    property p_eng_hold;
        eng_valid_o && !eng_ready_i |=> eng_valid_o && $stable(eng_dat_o);
    endproperty
    property p_vram_pulse;
        vram_rd_o |=> !vram_rd_o;
    endproperty

    a_ack_one: assert property (p_ack_one)
        else $error("register ack not one cycle after request");
    a_vmem_hold: assert property (p_vmem_hold)
        else $error("video request changed before ack");
    a_vmem_drop: assert property (p_vmem_drop)
        else $error("video request held after ack");
    a_vmem_align: assert property (p_vmem_align)
        else $error("video address not doubleword aligned");
    a_cmem_read: assert property (p_cmem_read)
        else $error("command fetch not an aligned read");
    a_lpb_full: assert property (p_lpb_full)
        else $error("output fifo written while full");
    a_lpb_pulse: assert property (p_lpb_pulse)
        else $error("output fifo write longer than one cycle");
    a_eng_hold: assert property (p_eng_hold)
        else $error("engine data dropped before ready");
    a_vram_pulse: assert property (p_vram_pulse)
        else $error("video memory read longer than one cycle");

    c_lpb: cover property (lpb_valid_o);
    c_eng: cover property (eng_valid_o && eng_ready_i);
    c_vwr: cover property (vmem_req_o.valid && vmem_req_o.we && vmem_ack_i);
endmodule // dcd_dma_checker

bind dcd_dma_top dcd_dma_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .vmem_req_o(vmem_req_o), .vmem_ack_i(vmem_ack_i), .wb_adr_i(wb_adr_i),
    .cmem_req_o(cmem_req_o), .lpb_valid_o(lpb_valid_o), .lpb_full_i(lpb_full_i),
    .vram_rd_o(vram_rd_o), .eng_valid_o(eng_valid_o), .eng_dat_o(eng_dat_o),
    .eng_ready_i(eng_ready_i)
);

// ### test/dcd_dma_top_tb.sv
// testbench: register-driven scenarios for both dma channels
`timescale 1ns/1ns
module dcd_dma_top_tb import dcd_pkg::*;;
    logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]   wb_sel_i;
    logic [15:0]  wb_adr_i;
    logic [31:0]  wb_dat_i, wb_dat_o, vmem_dat_i, vram_dat_i, lpb_dat_o;
    logic [31:0]  cmem_dat_i, eng_dat_o, rd;
    logic         vmem_ack_i, vram_rd_o, vram_valid_i, lpb_valid_o, lpb_full_i;
    logic         cmem_ack_i, eng_valid_o, eng_ready_i;
    dcd_mem_req_s vmem_req_o, cmem_req_o;
    int           failures, comparisons, cycles, vram_n, n0;
    logic [31:0]  lpb_q[$], eng_q[$], wa_q[$], wd_q[$];
    logic [15:0]  offs[7] = '{ADDR_VID_START, ADDR_VID_LEN, ADDR_CMD_BASE, ADDR_CMD_WPTR,
                              ADDR_CMD_RPTR, ADDR_VID_GO, ADDR_CMD_GO};
    logic [31:0]  me[5] = '{32'hffff_fffe, 32'h00ff_fffc, 32'hffff_f002, 32'h0001_fffc,
                            32'h0000_fffc};

    dcd_dma_top uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vmem_req_o(vmem_req_o),
        .vmem_ack_i(vmem_ack_i), .vmem_dat_i(vmem_dat_i), .vram_rd_o(vram_rd_o),
        .vram_valid_i(vram_valid_i), .vram_dat_i(vram_dat_i), .lpb_valid_o(lpb_valid_o),
        .lpb_dat_o(lpb_dat_o), .lpb_full_i(lpb_full_i), .cmem_req_o(cmem_req_o),
        .cmem_ack_i(cmem_ack_i), .cmem_dat_i(cmem_dat_i), .eng_valid_o(eng_valid_o),
        .eng_dat_o(eng_dat_o), .eng_ready_i(eng_ready_i)
    );
    // prompt memory for video, slow memory for commands
    dcd_mem_model #(.DELAY(0)) u_vmem (.clk_i(clk_i), .rst_i(rst_i), .req_i(vmem_req_o),
        .ack_o(vmem_ack_i), .dat_o(vmem_dat_i));
    dcd_mem_model #(.DELAY(3)) u_cmem (.clk_i(clk_i), .rst_i(rst_i), .req_i(cmem_req_o),
        .ack_o(cmem_ack_i), .dat_o(cmem_dat_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] pat(input logic [31:0] a);
        return a ^ 32'h5a5a_0000;
    endfunction

    // ********************
    // tasks
    // ********************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic poll(input string nm, input logic [15:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        do begin
            wb(1'b0, a, 32'h0000_0000);
            n++;
        end while (rd !== exp && n < 300);
        chk(nm, rd, exp);
    endtask
    task automatic cmd_run(input logic [31:0] base, input logic [31:0] rp,
                           input logic [31:0] a[3], input int cnt);
        eng_q.delete();
        wb(1'b1, ADDR_CMD_BASE, base);
        wb(1'b1, ADDR_CMD_RPTR, rp);
        wb(1'b1, ADDR_CMD_WPTR, 32'h0001_0004);
        repeat (20) @(posedge clk_i);
        chk("idle", 32'(eng_q.size()), 32'h0000_0000);
        wb(1'b1, ADDR_CMD_GO, 32'h0000_0001);
        poll("rptr", ADDR_CMD_RPTR, 32'h0000_0004);
        wb(1'b1, ADDR_CMD_GO, 32'h0000_0000);
        chk("fetches", 32'(eng_q.size()), 32'(cnt));
        for (int i = 0; i < cnt; i++) chk("fetch", eng_q[i], pat(a[i]));
    endtask
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // stimulus on the far side, monitors and timeout
    always @(posedge clk_i) begin
        lpb_full_i   <= (cycles % 8) >= 5;
        eng_ready_i  <= (cycles % 4) < 2;
        vram_valid_i <= vram_rd_o;
        vram_dat_i   <= vram_rd_o ? 32'hc000_0000 + 32'(vram_n) : ~vram_dat_i;
        if (vram_rd_o === 1'b1) vram_n <= vram_n + 1;
        if (lpb_valid_o === 1'b1) lpb_q.push_back(lpb_dat_o);
        if (eng_valid_o === 1'b1 && eng_ready_i === 1'b1) eng_q.push_back(eng_dat_o);
        if (vmem_req_o.valid === 1'b1 && vmem_req_o.we === 1'b1 && vmem_ack_i === 1'b1) begin
            wa_q.push_back(vmem_req_o.adr);
            wd_q.push_back(vmem_req_o.dat);
        end
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            failures++;
            wrap_up();
        end
    end

    // ********************
    // main sequence
    // ********************
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_sel_i, wb_adr_i, wb_dat_i} = {4'hf, 48'h0000_0000_0000};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (offs[i]) poll("reset", offs[i], 32'h0000_0000);
        poll("unmapped", 16'h85a0, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, offs[i], 32'hffff_ffff);
            poll("mask", offs[i], me[i]);
        end
        wb_sel_i <= 4'h3;
        wb(1'b1, ADDR_VID_START, 32'h0000_0000);
        wb_sel_i <= 4'hf;
        poll("lanes", ADDR_VID_START, 32'hffff_0000);
        $display("test 1 done");
        wb(1'b1, ADDR_VID_START, 32'h0000_1000);
        wb(1'b1, ADDR_VID_LEN, 32'h0000_0008);
        wb(1'b1, ADDR_VID_GO, 32'h0000_0001);
        poll("vid done", ADDR_VID_GO, 32'h0000_0000);
        chk("lpb count", 32'(lpb_q.size()), 32'h0000_0003);
        foreach (lpb_q[i]) chk("lpb", lpb_q[i], pat(32'h0000_1000 + 32'(i * 4)));
        $display("test 2 done");
        lpb_q.delete();
        n0 = vram_n;
        wb(1'b1, ADDR_VID_START, 32'h0000_2002);
        wb(1'b1, ADDR_VID_LEN, 32'h0000_0004);
        wb(1'b1, ADDR_VID_GO, 32'h0000_0001);
        poll("vid done", ADDR_VID_GO, 32'h0000_0000);
        chk("wr count", 32'(wa_q.size()), 32'h0000_0002);
        foreach (wa_q[i]) chk("wr adr", wa_q[i], 32'h0000_2000 + 32'(i * 4));
        foreach (wd_q[i]) chk("wr dat", wd_q[i], 32'hc000_0000 + 32'(n0 + i));
        chk("no lpb", 32'(lpb_q.size()), 32'h0000_0000);
        $display("test 3 done");
        wb(1'b1, ADDR_VID_START, 32'h0000_3000);
        wb(1'b1, ADDR_VID_LEN, 32'h0000_0400);
        wb(1'b1, ADDR_VID_GO, 32'h0000_0001);
        repeat (30) @(posedge clk_i);
        wb(1'b1, ADDR_VID_GO, 32'h0000_0000);
        poll("abort", ADDR_VID_GO, 32'h0000_0000);
        repeat (20) @(posedge clk_i);
        n0 = lpb_q.size();
        repeat (40) @(posedge clk_i);
        chk("stopped", 32'(lpb_q.size()), 32'(n0));
        $display("test 4 done");
        lpb_q.delete();
        wb(1'b1, ADDR_VID_START, 32'h0000_1000);
        wb(1'b1, ADDR_VID_LEN, 32'h0000_0040);
        wb(1'b1, ADDR_VID_GO, 32'h0000_0001);
        cmd_run(32'h0003_4000, 32'h0000_0ff8, '{32'h0003_4ff8, 32'h0003_4ffc, 32'h0003_4000}, 3);
        poll("vid done", ADDR_VID_GO, 32'h0000_0000);
        chk("lpb count", 32'(lpb_q.size()), 32'h0000_0011);
        $display("test 5 done");
        cmd_run(32'h0005_0002, 32'h0000_fffc, '{32'h0005_fffc, 32'h0005_0000, 32'h0000_0000}, 2);
        $display("test 6 done");
        wrap_up();
    end
endmodule // dcd_dma_top_tb
